/* File: rtl/stc_cfg.svh */
// Register map, field positions and timing constants of the seek/tune control block
//
// Functional notes
// R01: Wrap mode select 1 ends a seek at the upper or lower band edge.
// R02: Wrap mode select 0 wraps at a band edge and keeps seeking.
// R03: Power configuration bit 9 picks seek direction; 0 down, 1 up, default down.
// R04: Setting seek bit 8 starts a seek from the tuned channel in chosen direction.
// R05: Seek stops on a qualified channel, full sweep in wrap mode, or edge.
// R06: Seek end raises operation complete; no qualified channel also raises seek fail.
// R07: Host lowers seek bit before next operation; that clears complete and fail flags.
// R08: Writing seek bit 0 aborts a running seek; stepping stops.
// R09: Host writes zero to reserved power configuration and channel register bits.
// R10: Power configuration bit 0 requests powerup, bit 6 powerdown; both reset low.
// R11: Writing tune bit 15 high starts a tune to the selected channel.
// R12: Tune end raises operation complete; host lowering tune bit clears it.
// R13: Channel select is bits 9:0; band 00 gives spacing times channel plus 87.5 MHz.
// R14: Band 01 or 10 gives spacing times channel plus 76 MHz.
// R15: A seek never alters the host-written channel select field.
// R16: Readback channel tracks the tuned channel during seeks and at completion.
// R17: Step size comes from spacing field bits 5:4 of system configuration 2.
// R18: Operation complete reads as bit 14 of status register 0Ah.
// R19: No new seek or tune starts while operation complete is still high.
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define STC_IDX_PWR 8'h02
`define STC_IDX_CHAN 8'h03
`define STC_IDX_SYS2 8'h05
`define STC_IDX_STAT 8'h0A
`define STC_IDX_INTST 8'h10
`define STC_IDX_INTMSK 8'h11

// ==========================================================
// Field positions and writable masks
`define STC_PWR_MASK 16'hEF41
`define STC_PWR_ENABLE 0
`define STC_PWR_DISABLE 6
`define STC_PWR_SEEK 8
`define STC_PWR_SEEK_DIRECTION_SEL 9
`define STC_PWR_SEEK_WRAP_MODE_SEL 10
`define STC_CHAN_MASK 16'h83FF
`define STC_CHAN_TUNE 15
`define STC_STAT_STC 14
`define STC_STAT_SF 13
`define STC_INT_STC 0
`define STC_INT_SF 1
`define STC_RESET16 16'h0000

// ==========================================================
// Band plan in kHz
`define STC_BASE_HI 18'h155CC
`define STC_BASE_LO 18'h128E0
`define STC_TOP_WIDE 18'h1A5E0
`define STC_TOP_NARROW 18'h15F90
`define STC_SPACE_200 18'h000C8
`define STC_SPACE_100 18'h00064
`define STC_SPACE_50 18'h00032

// ==========================================================
// Timing
`define STC_CLK_MHZ 50
`define STC_TUNE_US 20
`define STC_DWELL_US 10

`endif

/* File: rtl/stc_pkg.sv */
// Types shared by the seek/tune control block
package stc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_TUNE, ST_STEP, ST_DWELL} stc_state_t;
  typedef logic [9:0] stc_chan_t;
  typedef logic [17:0] stc_khz_t;
endpackage

/* File: rtl/stc_seek_tune.sv */
// Seek and tune control registers with APB slave and interrupt
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stc_cfg.svh"

module stc_seek_tune
  import stc_pkg::*;
#(
  parameter int TUNE_CYCLES = `STC_TUNE_US * `STC_CLK_MHZ,
  parameter int DWELL_CYCLES = `STC_DWELL_US * `STC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chan_qualified,
  output logic [17:0] tuned_freq_khz,
  output logic power_up_req,
  output logic power_down_req,
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction

  function automatic stc_khz_t band_base(input logic [1:0] band);
    band_base = (band == 2'b00) ? `STC_BASE_HI : `STC_BASE_LO; // R13 R14
  endfunction

  function automatic stc_khz_t space_khz(input logic [1:0] sp);
    case (sp)
      2'b00: space_khz = `STC_SPACE_200;
      2'b01: space_khz = `STC_SPACE_100;
      default: space_khz = `STC_SPACE_50;
    endcase
  endfunction

  function automatic stc_khz_t chan_freq(input logic [1:0] band, input logic [1:0] sp,
                                         input stc_chan_t ch);
    logic [27:0] prod;
    prod = 28'(space_khz(sp)) * 28'(ch); // R17
    chan_freq = band_base(band) + prod[17:0]; // R13 R14
  endfunction

  // Divisions by constants only, so this stays small in gates
  function automatic stc_chan_t top_chan(input logic [1:0] band, input logic [1:0] sp);
    stc_khz_t span;
    stc_khz_t q;
    span = ((band == 2'b10) ? `STC_TOP_NARROW : `STC_TOP_WIDE) - band_base(band);
    case (sp)
      2'b00: q = span / `STC_SPACE_200;
      2'b01: q = span / `STC_SPACE_100;
      default: q = span / `STC_SPACE_50;
    endcase
    top_chan = q[9:0];
  endfunction

  // ==========================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // APB decode
  logic [15:0] pwr_reg;
  logic [15:0] chan_reg;
  logic [15:0] sys2_reg;
  logic [1:0] int_st_reg;
  logic [1:0] int_mask_reg;
  logic op_complete_flag;
  logic seek_fail_flag;
  stc_chan_t current_channel_readback;
  stc_state_t state_reg;

  logic acc;
  logic wr_en;
  logic hit;
  logic [15:0] rd_val;

  assign acc = psel && penable && pready;
  assign wr_en = acc && pwrite;

  always_comb begin
    hit = 1'b1;
    rd_val = 16'h0000;
    if (paddr == byte_addr(`STC_IDX_PWR)) begin
      rd_val = pwr_reg;
    end else if (paddr == byte_addr(`STC_IDX_CHAN)) begin
      rd_val = chan_reg;
    end else if (paddr == byte_addr(`STC_IDX_SYS2)) begin
      rd_val = sys2_reg;
    end else if (paddr == byte_addr(`STC_IDX_STAT)) begin
      rd_val[`STC_STAT_STC] = op_complete_flag; // R18
      rd_val[`STC_STAT_SF] = seek_fail_flag;
      rd_val[9:0] = current_channel_readback; // R16
    end else if (paddr == byte_addr(`STC_IDX_INTST)) begin
      rd_val[1:0] = int_st_reg;
    end else if (paddr == byte_addr(`STC_IDX_INTMSK)) begin
      rd_val[1:0] = int_mask_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= {16'h0000, rd_val};
      end
    end
  end

  // ==========================================================
  // Host registers; reserved power configuration and channel bits are dropped on write
  logic wr_pwr;
  logic wr_chan;

  assign wr_pwr = wr_en && (paddr == byte_addr(`STC_IDX_PWR));
  assign wr_chan = wr_en && (paddr == byte_addr(`STC_IDX_CHAN));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= `STC_RESET16;
      chan_reg <= `STC_RESET16;
      sys2_reg <= `STC_RESET16;
      int_mask_reg <= 2'b00;
    end else begin
      if (wr_pwr) begin
        pwr_reg <= pwdata[15:0] & `STC_PWR_MASK; // R09
      end
      if (wr_chan) begin
        chan_reg <= pwdata[15:0] & `STC_CHAN_MASK; // R15
      end
      if (wr_en && (paddr == byte_addr(`STC_IDX_SYS2))) begin
        sys2_reg <= pwdata[15:0];
      end
      if (wr_en && (paddr == byte_addr(`STC_IDX_INTMSK))) begin
        int_mask_reg <= pwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Seek and tune sequencer
  logic seek_bit;
  logic tune_bit;
  logic seek_up;
  logic stop_mode;
  logic [1:0] band;
  logic [1:0] space;
  stc_chan_t top_ch;
  stc_chan_t next_ch;
  stc_chan_t start_ch_reg;
  logic [15:0] cnt_reg;
  logic done_ok;
  logic done_fail;
  logic at_edge;

  assign seek_bit = pwr_reg[`STC_PWR_SEEK];
  assign tune_bit = chan_reg[`STC_CHAN_TUNE];
  assign seek_up = pwr_reg[`STC_PWR_SEEK_DIRECTION_SEL]; // R03
  assign stop_mode = pwr_reg[`STC_PWR_SEEK_WRAP_MODE_SEL];
  assign band = sys2_reg[7:6];
  assign space = sys2_reg[5:4];
  assign top_ch = top_chan(band, space);
  assign at_edge = seek_up ? (current_channel_readback >= top_ch)
                           : (current_channel_readback == 10'h000);

  // Wrap to the opposite edge when running off the band
  always_comb begin
    if (seek_up) begin
      next_ch = at_edge ? 10'h000 : current_channel_readback + 10'h001; // R02
    end else begin
      next_ch = at_edge ? top_ch : current_channel_readback - 10'h001; // R02
    end
  end

  assign done_ok = (state_reg == ST_TUNE && cnt_reg == 16'h0000)
                || (state_reg == ST_DWELL && seek_bit && cnt_reg == 16'h0000
                    && chan_qualified);
  assign done_fail = state_reg == ST_STEP && seek_bit
                  && ((stop_mode && at_edge) || next_ch == start_ch_reg); // R01 R05

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      start_ch_reg <= 10'h000;
      current_channel_readback <= 10'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (!op_complete_flag && seek_bit) begin // R19
            start_ch_reg <= current_channel_readback; // R04
            state_reg <= ST_STEP;
          end else if (!op_complete_flag && tune_bit) begin // R11 R19
            current_channel_readback <= chan_reg[9:0]; // R16
            cnt_reg <= 16'(TUNE_CYCLES - 1);
            state_reg <= ST_TUNE;
          end
        end
        ST_TUNE: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        ST_STEP: begin
          if (!seek_bit || done_fail) begin // R08 R05
            state_reg <= ST_IDLE;
          end else begin
            current_channel_readback <= next_ch; // R16
            cnt_reg <= 16'(DWELL_CYCLES - 1);
            state_reg <= ST_DWELL;
          end
        end
        default: begin
          if (!seek_bit || done_ok) begin // R08 R05
            state_reg <= ST_IDLE;
          end else if (cnt_reg == 16'h0000) begin
            state_reg <= ST_STEP;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Completion flags; clear only once both start bits are low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_complete_flag <= 1'b0;
      seek_fail_flag <= 1'b0;
    end else begin
      if (done_ok || done_fail) begin
        op_complete_flag <= 1'b1; // R06 R12
        seek_fail_flag <= done_fail; // R06
      end else if (state_reg == ST_IDLE && !seek_bit && !tune_bit) begin
        op_complete_flag <= 1'b0; // R07 R12
        seek_fail_flag <= 1'b0; // R07
      end
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear; a new event beats the clear
  logic [1:0] int_evt;

  assign int_evt = {done_fail, done_ok || done_fail};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_st_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      if (wr_en && (paddr == byte_addr(`STC_IDX_INTST))) begin
        int_st_reg <= (int_st_reg & ~pwdata[1:0]) | int_evt;
      end else begin
        int_st_reg <= int_st_reg | int_evt;
      end
      irq <= |(int_st_reg & int_mask_reg);
    end
  end

  // ==========================================================
  // Outputs to the tuner core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tuned_freq_khz <= 18'h00000;
      power_up_req <= 1'b0;
      power_down_req <= 1'b0;
    end else begin
      tuned_freq_khz <= chan_freq(band, space, current_channel_readback); // R13 R14 R17
      power_up_req <= pwr_reg[`STC_PWR_ENABLE]; // R10
      power_down_req <= pwr_reg[`STC_PWR_DISABLE]; // R10
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_start_blocked: assert property ( // R19
    state_reg == ST_IDLE && op_complete_flag |=> state_reg == ST_IDLE)
    else $error("operation started while complete flag high");

  chk_flag_clear: assert property ( // R07
    state_reg == ST_IDLE && op_complete_flag && !seek_bit && !tune_bit
    |=> !op_complete_flag && !seek_fail_flag)
    else $error("complete flag not cleared by start bits low");

  chk_fail_with_done: assert property ( // R06
    seek_fail_flag |-> op_complete_flag)
    else $error("seek fail without operation complete");

  chk_chan_hold: assert property ( // R15
    !wr_chan |=> $stable(chan_reg))
    else $error("channel select changed without a host write");

  chk_abort_seek: assert property ( // R08
    (state_reg == ST_STEP || state_reg == ST_DWELL) && !seek_bit
    |=> state_reg == ST_IDLE && !op_complete_flag)
    else $error("seek kept running after abort");

  chk_stop_edge: assert property ( // R01
    state_reg == ST_STEP && seek_bit && stop_mode && at_edge
    |=> seek_fail_flag && state_reg == ST_IDLE && $stable(current_channel_readback))
    else $error("stop mode seek passed the band edge");

  chk_wrap_up: assert property ( // R02
    state_reg == ST_STEP && seek_bit && !stop_mode && seek_up && at_edge
    && start_ch_reg != 10'h000 |=> current_channel_readback == 10'h000)
    else $error("upward seek did not wrap to the low edge");

  chk_step_down: assert property ( // R03
    state_reg == ST_STEP && seek_bit && !seek_up && !at_edge && !done_fail
    |=> current_channel_readback == $past(current_channel_readback) - 10'h001)
    else $error("downward seek stepped the wrong way");
  chk_tune_done: assert property ( // R11
    (state_reg == ST_IDLE && !op_complete_flag && !seek_bit && tune_bit
     |=> current_channel_readback == $past(chan_reg[9:0]) && cnt_reg == 16'(TUNE_CYCLES - 1))
    and (state_reg == ST_TUNE && cnt_reg == 16'h0000 |=> op_complete_flag))
    else $error("tune did not complete to the selected channel");

  chk_irq_level: assert property (
    |(int_st_reg & int_mask_reg) |=> irq)
    else $error("masked-in status did not raise interrupt");

  chk_apb_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB ready not one cycle after access");

  cov_tune: cover property (state_reg == ST_TUNE ##1 state_reg == ST_IDLE);
  cov_seek_ok: cover property (state_reg == ST_DWELL && done_ok);
  cov_seek_fail: cover property (done_fail);
  cov_abort: cover property (state_reg == ST_DWELL && !seek_bit);

endmodule
`default_nettype wire

/* File: tb/stc_rf_model.sv */
// Behavioural RF core model that qualifies one chosen frequency
`timescale 1ns/1ps
`default_nettype none

module stc_rf_model (
  input wire logic [17:0] tuned_freq_khz,
  input wire logic [17:0] target_khz,
  output logic chan_qualified
);
  // ==========================================================
  // Qualification
  // Exact match only, so a seek that oversteps is never rescued
  assign chan_qualified = (tuned_freq_khz == target_khz);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the seek/tune control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] e;
    logic x;
  } stc_row_t;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, chan_qualified;
  logic power_up_req, power_down_req, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r1;
  logic [17:0] tuned_freq_khz, target_khz;
  int err_total, n_tests;
  stc_row_t rows [12];

  // ==========================================================
  // Instances
  // Short tune and dwell counts keep seeks to a few hundred cycles
  stc_seek_tune #(.TUNE_CYCLES(4), .DWELL_CYCLES(3)) u_stc_seek_tune (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_qualified(chan_qualified),
    .tuned_freq_khz(tuned_freq_khz), .power_up_req(power_up_req),
    .power_down_req(power_down_req), .irq(irq));
  stc_rf_model u_stc_rf_model (.tuned_freq_khz(tuned_freq_khz),
    .target_khz(target_khz), .chan_qualified(chan_qualified));

  always #10 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED t=%0t bus answer missing", $time);
      conclude();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask

  // Polls status; a hung seek ends the run instead of the bench
  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[14] !== 1'b1) begin
      if (n == 300) begin
        err_total++;
        $display("CHECK FAILED t=%0t completion missing", $time);
        conclude();
      end
      apb(1'b0, 8'h28, 16'h0000);
      n++;
    end
  endtask

  task automatic tune(input logic [15:0] sys2, input logic [9:0] ch, input logic [17:0] khz);
    apb(1'b1, 8'h14, sys2);
    apb(1'b1, 8'h0C, {6'h20, ch});
    wait_done();
    chk(rd, {16'h0000, 6'h10, ch});
    chk({14'h0000, tuned_freq_khz}, {14'h0000, khz});
    apb(1'b1, 8'h0C, {6'h00, ch});
    rdchk(8'h28, {22'h000000, ch});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    target_khz = 18'h00000;
    err_total = 0;
    n_tests = 0;
    rows = '{
      '{1'b0, 8'h08, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 8'h0C, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, 8'h28, 16'h0000, 16'h0000, 1'b0}, '{1'b1, 8'h08, 16'hFCFF, 16'h0000, 1'b0},
      '{1'b0, 8'h08, 16'h0000, 16'hEC41, 1'b0}, '{1'b1, 8'h08, 16'h0000, 16'h0000, 1'b0},
      '{1'b1, 8'h0C, 16'h7FFF, 16'h0000, 1'b0}, '{1'b0, 8'h0C, 16'h0000, 16'h03FF, 1'b0},
      '{1'b1, 8'h28, 16'hFFFF, 16'h0000, 1'b0}, '{1'b0, 8'h28, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, 8'h30, 16'h0000, 16'h0000, 1'b1}, '{1'b1, 8'h30, 16'h1234, 16'h0000, 1'b1}};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk({31'h0, er}, {31'h0, rows[i].x});
      if (!rows[i].w) begin
        chk(rd, {16'h0000, rows[i].e});
      end
    end
    apb(1'b1, 8'h08, 16'h0041);
    repeat (2) @(posedge clk);
    chk({30'h0, power_up_req, power_down_req}, 32'h3);
    apb(1'b1, 8'h08, 16'h0000);
    tune(16'h0050, 10'd10, 18'd77000);
    tune(16'h00A0, 10'd3, 18'd76150);
    tune(16'h0000, 10'd5, 18'd88500);
    // Start bits left high must not launch anything
    apb(1'b1, 8'h0C, 16'h8005);
    wait_done();
    apb(1'b1, 8'h08, 16'h0300);
    repeat (20) @(posedge clk);
    rdchk(8'h28, 32'h4005);
    apb(1'b1, 8'h08, 16'h0000);
    rdchk(8'h28, 32'h4005);
    apb(1'b1, 8'h0C, 16'h0005);
    rdchk(8'h28, 32'h0005);
    apb(1'b1, 8'h40, 16'h0003);
    target_khz <= 18'd89100;
    apb(1'b1, 8'h08, 16'h0700);
    wait_done();
    chk(rd, 32'h4008);
    rdchk(8'h0C, 32'h0005);
    chk({14'h0000, tuned_freq_khz}, 32'd89100);
    rdchk(8'h40, 32'h0001);
    apb(1'b1, 8'h08, 16'h0000);
    rdchk(8'h28, 32'h0008);
    target_khz <= 18'h00000;
    apb(1'b1, 8'h08, 16'h0500);
    wait_done();
    chk(rd, 32'h6000);
    rdchk(8'h40, 32'h0003);
    apb(1'b1, 8'h08, 16'h0000);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h44, 16'h0001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h40, 16'h0001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdchk(8'h40, 32'h0002);
    apb(1'b1, 8'h40, 16'h0002);
    rdchk(8'h40, 32'h0000);
    target_khz <= 18'd76200;
    apb(1'b1, 8'h14, 16'h0080);
    apb(1'b1, 8'h0C, 16'h8045);
    wait_done();
    apb(1'b1, 8'h0C, 16'h0045);
    apb(1'b1, 8'h08, 16'h0300);
    wait_done();
    chk(rd, 32'h4001);
    apb(1'b1, 8'h08, 16'h0000);
    target_khz <= 18'h00000;
    apb(1'b1, 8'h08, 16'h0300);
    wait_done();
    chk(rd & 32'h6000, 32'h6000);
    apb(1'b1, 8'h08, 16'h0000);
    apb(1'b1, 8'h08, 16'h0300);
    repeat (30) @(posedge clk);
    apb(1'b1, 8'h08, 16'h0000);
    apb(1'b0, 8'h28, 16'h0000);
    r1 = rd;
    repeat (30) @(posedge clk);
    rdchk(8'h28, r1);
    chk(r1 & 32'h6000, 32'h0);
    // Reset in mid-run brings registers back to defaults
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(8'h08, 32'h0000);
    rdchk(8'h0C, 32'h0000);
    conclude();
  end
endmodule
`default_nettype wire
